// file: design/duit_pkg.sv
// Package with offsets, field positions and reset values of the DUART
// interrupt, timer and input block. Assumes an 8-bit AXI4-Lite byte address.
package duit_pkg;
  // Byte addresses of the registers.
  localparam logic [7:0] OFF_INPUT_CHANGE = 8'h00;
  localparam logic [7:0] OFF_AUX_CONTROL = 8'h04;
  localparam logic [7:0] OFF_INT_STATUS = 8'h08;
  localparam logic [7:0] OFF_INT_MASK = 8'h0c;
  localparam logic [7:0] OFF_PRELOAD_UPPER = 8'h10;
  localparam logic [7:0] OFF_PRELOAD_LOWER = 8'h14;
  localparam logic [7:0] OFF_COUNT_UPPER = 8'h18;
  localparam logic [7:0] OFF_COUNT_LOWER = 8'h1c;
  localparam logic [7:0] OFF_SCRATCHPAD = 8'h20;
  localparam logic [7:0] OFF_INPUT_LEVELS = 8'h24;
  localparam logic [7:0] OFF_START_READ = 8'h28;
  localparam logic [7:0] OFF_STOP_READ = 8'h2c;
  localparam logic [7:0] OFF_CHAN_A_CMD = 8'h30;
  localparam logic [7:0] OFF_CHAN_B_CMD = 8'h34;
  // Value of every host-writable byte register after reset.
  localparam logic [7:0] RST_BYTE = 8'h00;
  // Counter/timer output level after reset and when stopped.
  localparam logic CT_OUT_RST = 1'b1;
  // Auxiliary control field positions.
  localparam int ACR_MODE_LSB = 4;
  localparam int ACR_BAUD_BIT = 7;
  // Miscellaneous command that clears a break-change flag.
  localparam logic [3:0] MISC_CLR_BREAK = 4'h5;
  // Division ratio of the by-16 prescalers, as a 4-bit wrap counter.
  localparam logic [3:0] DIV16_LAST = 4'hf;
  // Interrupt status bit positions.
  localparam int ISR_TXA = 0;
  localparam int ISR_RXA = 1;
  localparam int ISR_BRKA = 2;
  localparam int ISR_CT = 3;
  localparam int ISR_TXB = 4;
  localparam int ISR_RXB = 5;
  localparam int ISR_BRKB = 6;
  localparam int ISR_INP = 7;
  // Counter/timer mode and clock source codes.
  localparam logic [2:0] CT_CNT_IP2 = 3'h0;
  localparam logic [2:0] CT_CNT_TXA = 3'h1;
  localparam logic [2:0] CT_CNT_TXB = 3'h2;
  localparam logic [2:0] CT_CNT_X16 = 3'h3;
  localparam logic [2:0] CT_TMR_IP2 = 3'h4;
  localparam logic [2:0] CT_TMR_I16 = 3'h5;
  localparam logic [2:0] CT_TMR_XTL = 3'h6;
  localparam logic [2:0] CT_TMR_X16 = 3'h7;
  // AXI response codes.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: design/duit_top.sv
// Interrupt status and mask, auxiliary control, input change detection,
// 16-bit counter/timer, scratchpad and input level registers of a DUART.
// Assumes clk is the crystal clock, pins are asynchronous, and the channel
// logic delivers trigger-level results and break-change pulses on clk.
// Function
// - Change register low nibble shows pins 3-0
// - Upper nibble latches changes, cleared on read
// - Enable bits route pin changes to status 7
// - Bits 6-4 pick counter/timer mode and clock
// - Bit 7 selects baud set two
// - Interrupt low when status AND mask nonzero
// - Status read clears nothing, ignores mask
// - Reset clears flag bits 2,3,6,7
// - Bits 0,4 follow transmit trigger levels
// - Bits 1,5 follow receive trigger levels
// - Bits 2,6 set on break, cleared by 5
// - Bit 3 on terminal count or rise
// - Bit 7 set by change, cleared on read
// - Mask affects only the interrupt line
// - Preload is upper and lower byte
// - Count registers return current count in counter mode
// - Counter start reloads preload, fresh cycle
// - Timer count unreadable, stop clears flag only
// - Timer preload change after current half-period
// - Scratchpad stores and returns one byte
// - Input levels show pins 0-6, bit 7 zero
// - Start and stop registers act on read
`timescale 1ns/1ps
`default_nettype none
module duit_top
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [6:0] input_pins,
  input wire logic chan_a_tx_1x_clock,
  input wire logic chan_b_tx_1x_clock,
  input wire logic [1:0] tx_trig_met,
  input wire logic [1:0] rx_trig_met,
  input wire logic [1:0] break_change,
  output logic irq_n,
  output logic ct_output,
  output logic baud_set_two
);
  import duit_pkg::*;

  // Synchroniser stages for pins and the transmit 1x clocks.
  logic [8:0] sync1_q;
  logic [8:0] sync2_q;
  logic [8:0] prev_q;
  logic [6:0] pin_lvl;
  logic [3:0] chg;
  logic ip2_rise, txa_rise, txb_rise;
  // Register storage.
  logic [7:0] acr_q, imr_q, pu_q, pl_q, gpr_q;
  logic [3:0] ipc_flag_q;
  logic isr7_q, isr3_q, brk_a_q, brk_b_q;
  logic [7:0] isr_w;
  logic irq_n_q;
  // Counter/timer state.
  logic [15:0] cnt_q;
  logic running_q, ct_out_q;
  logic [3:0] xdiv_q, idiv_q;
  logic x16_tick, i16_tick, tick, is_timer, reload, tc, tmr_rise;
  logic [2:0] mode;
  // Bus state.
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic aw_have_q, w_have_q, bvalid_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic wr_fire, rd_fire, wr_en;
  logic rd_ipc, rd_start, rd_stop, clr_brk_a, clr_brk_b;
  logic [7:0] rd_byte;
  logic rd_hit, wr_hit;

  // Two flip-flops before any logic reads a pin; prev_q holds the last
  // synchronised level for change and edge detection.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sync1_q <= 9'h000;
      sync2_q <= 9'h000;
      prev_q <= 9'h000;
    end
    else
    begin
      sync1_q <= {chan_b_tx_1x_clock, chan_a_tx_1x_clock, input_pins};
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  // Level, change and rising-edge terms of the synchronised pins.
  assign pin_lvl = sync2_q[6:0];
  assign chg = sync2_q[3:0] ^ prev_q[3:0];
  assign ip2_rise = sync2_q[2] & ~prev_q[2];
  assign txa_rise = sync2_q[7] & ~prev_q[7];
  assign txb_rise = sync2_q[8] & ~prev_q[8];

  // Write channel: address and data are taken in either order.
  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready = !w_have_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
  assign wr_en = wr_fire && wstrb_q[0];

  // Capture address and data, then answer once both are held.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        // Both parts are consumed; the response follows.
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_q && s_axi_bready)
      begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Write address decode; read-only offsets accept and ignore writes.
  always_comb
  begin
    case (awaddr_q)
      OFF_INPUT_CHANGE, OFF_AUX_CONTROL, OFF_INT_STATUS, OFF_INT_MASK,
      OFF_PRELOAD_UPPER, OFF_PRELOAD_LOWER, OFF_COUNT_UPPER,
      OFF_COUNT_LOWER, OFF_SCRATCHPAD, OFF_INPUT_LEVELS, OFF_START_READ,
      OFF_STOP_READ, OFF_CHAN_A_CMD, OFF_CHAN_B_CMD: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // Break-change clear commands on the channel command offsets.
  assign clr_brk_a = wr_en && awaddr_q == OFF_CHAN_A_CMD &&
                     wdata_q[7:4] == MISC_CLR_BREAK;
  assign clr_brk_b = wr_en && awaddr_q == OFF_CHAN_B_CMD &&
                     wdata_q[7:4] == MISC_CLR_BREAK;

  // Host-writable control registers.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      acr_q <= RST_BYTE;
      imr_q <= RST_BYTE;
      pu_q <= RST_BYTE;
      pl_q <= RST_BYTE;
      gpr_q <= RST_BYTE;
    end
    else if (wr_en)
    begin
      case (awaddr_q)
        OFF_AUX_CONTROL: acr_q <= wdata_q[7:0];
        OFF_INT_MASK: imr_q <= wdata_q[7:0];
        OFF_PRELOAD_UPPER: pu_q <= wdata_q[7:0];
        OFF_PRELOAD_LOWER: pl_q <= wdata_q[7:0];
        OFF_SCRATCHPAD: gpr_q <= wdata_q[7:0];
        default: ;
      endcase
    end
  end

  // Baud table select goes straight to the channel logic.
  assign baud_set_two = acr_q[ACR_BAUD_BIT];

  // Read channel: one read at a time, data registered with the answer.
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign rd_ipc = rd_fire && s_axi_araddr == OFF_INPUT_CHANGE;
  assign rd_start = rd_fire && s_axi_araddr == OFF_START_READ;
  assign rd_stop = rd_fire && s_axi_araddr == OFF_STOP_READ;

  // Read multiplexer; the timer hides its count, strobe reads return zero.
  always_comb
  begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      OFF_INPUT_CHANGE: rd_byte = {ipc_flag_q, pin_lvl[3:0]};
      OFF_AUX_CONTROL: rd_byte = acr_q;
      OFF_INT_STATUS: rd_byte = isr_w;
      OFF_INT_MASK: rd_byte = imr_q;
      OFF_PRELOAD_UPPER: rd_byte = pu_q;
      OFF_PRELOAD_LOWER: rd_byte = pl_q;
      OFF_COUNT_UPPER: rd_byte = is_timer ? 8'h00 : cnt_q[15:8];
      OFF_COUNT_LOWER: rd_byte = is_timer ? 8'h00 : cnt_q[7:0];
      OFF_SCRATCHPAD: rd_byte = gpr_q;
      OFF_INPUT_LEVELS: rd_byte = {1'b0, pin_lvl};
      OFF_START_READ, OFF_STOP_READ, OFF_CHAN_A_CMD, OFF_CHAN_B_CMD:
        rd_byte = 8'h00;
      default:
      begin
        rd_byte = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  // Hold the read answer until the master takes it.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end
    else if (rd_fire)
    begin
      rvalid_q <= 1'b1;
      rdata_q <= {24'h000000, rd_byte};
      rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rvalid_q && s_axi_rready)
    begin
      rvalid_q <= 1'b0;
    end
  end

  // Change flags latch each change on pins 3-0; a read clears them, but a change
  // in the read cycle wins and stays visible for the next read.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ipc_flag_q <= 4'h0;
      isr7_q <= 1'b0;
    end
    else
    begin
      ipc_flag_q <= (rd_ipc ? 4'h0 : ipc_flag_q) | chg;
      // Only enabled pins raise the input change interrupt source.
      isr7_q <= (rd_ipc ? 1'b0 : isr7_q) | (|(chg & acr_q[3:0]));
    end
  end

  // Break-change flags; a new break edge beats a clear command.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      brk_a_q <= 1'b0;
      brk_b_q <= 1'b0;
    end
    else
    begin
      brk_a_q <= (clr_brk_a ? 1'b0 : brk_a_q) | break_change[0];
      brk_b_q <= (clr_brk_b ? 1'b0 : brk_b_q) | break_change[1];
    end
  end

  // Status word: FIFO levels pass through, events come from flags.
  always_comb
  begin
    isr_w = 8'h00;
    isr_w[ISR_TXA] = tx_trig_met[0];
    isr_w[ISR_RXA] = rx_trig_met[0];
    isr_w[ISR_BRKA] = brk_a_q;
    isr_w[ISR_CT] = isr3_q;
    isr_w[ISR_TXB] = tx_trig_met[1];
    isr_w[ISR_RXB] = rx_trig_met[1];
    isr_w[ISR_BRKB] = brk_b_q;
    isr_w[ISR_INP] = isr7_q;
  end

  // Interrupt line; the mask touches nothing but this output.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      irq_n_q <= 1'b1;
    end
    else
    begin
      irq_n_q <= ~|(isr_w & imr_q);
    end
  end
  assign irq_n = irq_n_q;

  // By-16 prescalers for the crystal clock and for pin 2 edges.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      xdiv_q <= 4'h0;
      idiv_q <= 4'h0;
    end
    else
    begin
      xdiv_q <= xdiv_q + 4'h1;
      if (ip2_rise)
      begin
        idiv_q <= idiv_q + 4'h1;
      end
    end
  end
  assign x16_tick = xdiv_q == DIV16_LAST;
  assign i16_tick = ip2_rise && idiv_q == DIV16_LAST;

  // Clock source select for the counter/timer.
  assign mode = acr_q[ACR_MODE_LSB +: 3];
  assign is_timer = mode[2];
  always_comb
  begin
    case (mode)
      CT_CNT_IP2: tick = ip2_rise;
      CT_CNT_TXA: tick = txa_rise;
      CT_CNT_TXB: tick = txb_rise;
      CT_CNT_X16: tick = x16_tick;
      CT_TMR_IP2: tick = ip2_rise;
      CT_TMR_I16: tick = i16_tick;
      CT_TMR_XTL: tick = 1'b1;
      CT_TMR_X16: tick = x16_tick;
      default: tick = 1'b0;
    endcase
  end

  // Timer half-period ends at count one or zero; counter terminal count at count one.
  assign reload = running_q && tick && is_timer && cnt_q <= 16'h0001;
  assign tc = running_q && tick && !is_timer && cnt_q == 16'h0001;
  assign tmr_rise = reload && !ct_out_q;

  // Run state: a start read runs both modes, a stop halts only the counter.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      running_q <= 1'b0;
    end
    else if (rd_start)
    begin
      running_q <= 1'b1;
    end
    else if (rd_stop && !is_timer)
    begin
      running_q <= 1'b0;
    end
  end

  // Down counter; the preload is only sampled at a start or a reload,
  // so a new preload waits for a restart or the next half-period.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_q <= 16'h0000;
    end
    else if (rd_start)
    begin
      cnt_q <= {pu_q, pl_q};
    end
    else if (reload)
    begin
      cnt_q <= {pu_q, pl_q};
    end
    else if (running_q && tick)
    begin
      cnt_q <= cnt_q - 16'h0001;
    end
  end

  // Output: square wave in timer mode, low after terminal count in
  // counter mode until a stop.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ct_out_q <= CT_OUT_RST;
    end
    else if (reload)
    begin
      ct_out_q <= ~ct_out_q;
    end
    else if (tc)
    begin
      ct_out_q <= 1'b0;
    end
    else if (rd_stop && !is_timer)
    begin
      ct_out_q <= CT_OUT_RST;
    end
  end
  assign ct_output = ct_out_q;

  // Ready flag; a set in the stop cycle wins over the clear.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      isr3_q <= 1'b0;
    end
    else
    begin
      isr3_q <= (rd_stop ? 1'b0 : isr3_q) | tc | tmr_rise;
    end
  end

  // Checks on the logic above.
  chk_irq_level: assert property (@(posedge clk) disable iff (!rstn)
    ##1 irq_n == ~|($past(isr_w) & $past(imr_q)))
    else $error("interrupt line disagrees with status and mask");
  chk_ipc_clear: assert property (@(posedge clk) disable iff (!rstn)
    rd_ipc && chg == 4'h0 |=> ipc_flag_q == 4'h0)
    else $error("change flags not cleared by read");
  chk_inp_set: assert property (@(posedge clk) disable iff (!rstn)
    |(chg & acr_q[3:0]) |=> isr7_q ##1 isr7_q || $past(rd_ipc))
    else $error("enabled change did not set status 7");
  chk_inp_masked: assert property (@(posedge clk) disable iff (!rstn)
    !isr7_q && (chg & acr_q[3:0]) == 4'h0 |=> !isr7_q)
    else $error("disabled change set status 7");
  chk_isr_read: assert property (@(posedge clk) disable iff (!rstn)
    rd_fire && s_axi_araddr == OFF_INT_STATUS && !rd_stop |=>
    isr3_q == $past(isr3_q) || $past(tc || tmr_rise))
    else $error("status read altered a source");
  chk_brk_clear: assert property (@(posedge clk) disable iff (!rstn)
    clr_brk_a && !break_change[0] |=> !brk_a_q)
    else $error("break flag not cleared by command");
  chk_timer_stop: assert property (@(posedge clk) disable iff (!rstn)
    is_timer && running_q && rd_stop && !rd_start && !tmr_rise |=> running_q && !isr3_q)
    else $error("stop halted the timer or kept its flag");
  chk_start_load: assert property (@(posedge clk) disable iff (!rstn)
    rd_start |=> cnt_q == $past({pu_q, pl_q}))
    else $error("start did not load the preload");
  chk_tc_flag: assert property (@(posedge clk) disable iff (!rstn)
    tc |=> isr3_q && !ct_out_q)
    else $error("terminal count missed");
  chk_levels_rd: assert property (@(posedge clk) disable iff (!rstn)
    rd_fire && s_axi_araddr == OFF_INPUT_LEVELS |=>
    s_axi_rvalid && s_axi_rdata[31:7] == 25'h0000000)
    else $error("input level read has upper bits set");
  chk_scratch_wr: assert property (@(posedge clk) disable iff (!rstn)
    wr_en && awaddr_q == OFF_SCRATCHPAD |=> gpr_q == $past(wdata_q[7:0]))
    else $error("scratchpad write lost");
  cov_irq: cover property (@(posedge clk) disable iff (!rstn) $fell(irq_n));
  cov_tmr: cover property (@(posedge clk) disable iff (!rstn) tmr_rise);
  cov_tc: cover property (@(posedge clk) disable iff (!rstn) tc);
  cov_chg: cover property (@(posedge clk) disable iff (!rstn) rd_ipc && isr7_q);
endmodule
`default_nettype wire

// file: tb/duit_host_model.sv
// Host model: an AXI4-Lite master reaching the register block.
// Assumes the bench clock; the bench calls its tasks one at a time.
`timescale 1ns/1ps
`default_nettype none
module duit_host_model
(
  input wire logic clk,
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic [1:0] bresp,
  output logic bready,
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  // The bus idles with every request low.
  initial
  begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end
  // One byte write; each channel is released when it is taken.
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    wstrb <= 4'h1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
    end
    while (!bvalid);
    // The response code is taken at the edge that sees bvalid.
    r = bresp;
    bready <= 1'b0;
  endtask
  // One read; data and response are taken at the edge that sees rvalid.
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arvalid && arready)
        arvalid <= 1'b0;
    end
    while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
endmodule
`default_nettype wire

// file: tb/duit_top_tb.sv
// Self-checking bench of the interrupt, timer and input block.
// Assumes duit_pkg and the host model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module duit_top_tb;
  import duit_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, irq_n, ct_output, baud_set_two;
  logic [31:0] wdata, rdata, rw;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs, tv;
  logic [6:0] pins = 7'h00;
  logic [1:0] tx_trig = 2'b00;
  logic [1:0] rx_trig = 2'b00;
  logic [1:0] brk = 2'b00;
  // Transmit 1x clocks of channel A (bit 0) and B (bit 1).
  logic [1:0] txc = 2'b00;
  logic [7:0] seed = 8'h56;
  logic [7:0] pv;
  logic last_ct;
  int num_errors = 0;
  int samples_checked = 0;
  int k, n;
  // Free-running 25 MHz clock.
  always #20 clk = ~clk;
  duit_top i_duit_top (.clk(clk), .rstn(rstn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .input_pins(pins), .chan_a_tx_1x_clock(txc[0]),
    .chan_b_tx_1x_clock(txc[1]), .tx_trig_met(tx_trig), .rx_trig_met(rx_trig),
    .break_change(brk), .irq_n(irq_n), .ct_output(ct_output),
    .baud_set_two(baud_set_two));
  duit_host_model i_duit_host_model (.clk(clk), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bvalid(bvalid), .bresp(bresp), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready));
  // Pseudo-random byte source.
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // Expected status from the channel trigger levels.
  function automatic logic [7:0] trig_st(input logic [1:0] t, input logic [1:0] r);
    return {2'b00, r[1], t[1], 2'b00, r[0], t[0]};
  endfunction
  task automatic report_and_stop;
    $display("mismatches %0d comparisons %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_duit_host_model.wr(a, d, rs);
    chk("bresp", {30'h0, RESP_OKAY}, {30'h0, rs});
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] e);
    i_duit_host_model.rd(a, rw, rs);
    chk(nm, {24'h000000, e}, rw);
    chk("rresp", {30'h0, RESP_OKAY}, {30'h0, rs});
  endtask
  // Drive the input pins to new levels and let the synchroniser settle.
  task automatic set_pins(input logic [6:0] p);
    @(posedge clk);
    pins <= p;
    cyc(5);
  endtask
  // A single rising and falling edge on input pin 2.
  task automatic pulse2;
    set_pins(pins | 7'h04);
    set_pins(pins & 7'h7b);
  endtask
  // One rising and falling edge on the transmit 1x clocks chosen by c.
  task automatic txc_pulse(input logic [1:0] c);
    @(posedge clk);
    txc <= c;
    cyc(5);
    @(posedge clk);
    txc <= 2'b00;
    cyc(5);
  endtask
  // Cuts a hung run short.
  initial
  begin
    cyc(20000);
    num_errors++;
    report_and_stop;
  end
  // Main sequence.
  initial
  begin
    cyc(8);
    rstn <= 1'b1;
    cyc(2);
    rdc("status", OFF_INT_STATUS, 8'h00);
    chk("irq_n", 1, irq_n);
    for (k = 0; k < 4; k++)
    begin
      seed = lfsr(seed);
      wr(OFF_SCRATCHPAD, seed);
      rdc("scratchpad", OFF_SCRATCHPAD, seed);
    end
    // Mode codes 1 to 7 are stored while the counter/timer is idle.
    for (k = 1; k < 8; k++)
    begin
      wr(OFF_AUX_CONTROL, 8'(k << 4));
      rdc("aux", OFF_AUX_CONTROL, 8'(k << 4));
    end
    wr(OFF_AUX_CONTROL, 8'h80);
    chk("baud", 1, baud_set_two);
    wr(OFF_AUX_CONTROL, 8'h00);
    i_duit_host_model.rd(8'h3c, rw, rs);
    chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, rs});
    // A write to an unmapped offset is refused with an error response.
    i_duit_host_model.wr(8'h3c, 8'h00, rs);
    chk("unmapped bresp", {30'h0, RESP_SLVERR}, {30'h0, rs});
    seed = lfsr(seed);
    pv = seed;
    set_pins(pv[6:0]);
    rdc("levels", OFF_INPUT_LEVELS, {1'b0, pv[6:0]});
    rdc("change", OFF_INPUT_CHANGE, {pv[3:0], pv[3:0]});
    rdc("change", OFF_INPUT_CHANGE, {4'h0, pv[3:0]});
    rdc("status", OFF_INT_STATUS, 8'h00);
    // Pins 0 and 2 enabled; a pin 1 change must stay quiet.
    wr(OFF_AUX_CONTROL, 8'h05);
    set_pins(pins ^ 7'h02);
    rdc("status", OFF_INT_STATUS, 8'h00);
    rdc("change", OFF_INPUT_CHANGE, {4'h2, pins[3:0]});
    set_pins(pins ^ 7'h04);
    wr(OFF_INT_MASK, 8'h80);
    rdc("status", OFF_INT_STATUS, 8'h80);
    rdc("status", OFF_INT_STATUS, 8'h80);
    chk("irq_n", 0, irq_n);
    wr(OFF_INT_MASK, 8'h7f);
    rdc("status", OFF_INT_STATUS, 8'h80);
    chk("irq_n", 1, irq_n);
    rdc("change", OFF_INPUT_CHANGE, {4'h4, pins[3:0]});
    rdc("status", OFF_INT_STATUS, 8'h00);
    wr(OFF_INT_MASK, 8'hff);
    for (k = 0; k < 4; k++)
    begin
      tv = 2'(k);
      @(posedge clk);
      tx_trig <= tv;
      rx_trig <= ~tv;
      cyc(2);
      rdc("status", OFF_INT_STATUS, trig_st(tv, ~tv));
      chk("irq_n", 0, irq_n);
    end
    @(posedge clk);
    tx_trig <= 2'b00;
    rx_trig <= 2'b00;
    brk <= 2'b11;
    @(posedge clk);
    brk <= 2'b00;
    cyc(2);
    rdc("status", OFF_INT_STATUS, 8'h44);
    wr(OFF_CHAN_A_CMD, 8'h40);
    rdc("status", OFF_INT_STATUS, 8'h44);
    wr(OFF_CHAN_A_CMD, 8'h50);
    rdc("status", OFF_INT_STATUS, 8'h40);
    wr(OFF_CHAN_B_CMD, 8'h50);
    rdc("status", OFF_INT_STATUS, 8'h00);
    chk("irq_n", 1, irq_n);
    // Counter on pin 2 edges; a preload written mid-run waits for restart.
    wr(OFF_AUX_CONTROL, 8'h00);
    set_pins(7'h00);
    wr(OFF_PRELOAD_UPPER, 8'h00);
    wr(OFF_PRELOAD_LOWER, 8'h03);
    i_duit_host_model.rd(OFF_START_READ, rw, rs);
    pulse2;
    pulse2;
    wr(OFF_PRELOAD_UPPER, 8'h01);
    wr(OFF_PRELOAD_LOWER, 8'h05);
    pulse2;
    rdc("status", OFF_INT_STATUS, 8'h08);
    chk("ct_output", 0, ct_output);
    i_duit_host_model.rd(OFF_STOP_READ, rw, rs);
    rdc("status", OFF_INT_STATUS, 8'h00);
    chk("ct_output", 1, ct_output);
    rdc("count hi", OFF_COUNT_UPPER, 8'h00);
    rdc("count lo", OFF_COUNT_LOWER, 8'h00);
    i_duit_host_model.rd(OFF_START_READ, rw, rs);
    pulse2;
    pulse2;
    i_duit_host_model.rd(OFF_STOP_READ, rw, rs);
    rdc("count hi", OFF_COUNT_UPPER, 8'h01);
    rdc("count lo", OFF_COUNT_LOWER, 8'h03);
    // Counter on the A and B transmit clocks and on the crystal by 16:
    // for A and B, edges of the other clock must not count, its own edges must.
    wr(OFF_PRELOAD_UPPER, 8'h00);
    for (k = 1; k < 4; k++)
    begin
      wr(OFF_AUX_CONTROL, 8'(k << 4));
      wr(OFF_PRELOAD_LOWER, (k == 3) ? 8'h04 : 8'h02);
      i_duit_host_model.rd(OFF_START_READ, rw, rs);
      txc_pulse(2'(3 - k));
      txc_pulse(2'(3 - k));
      rdc("ct early", OFF_INT_STATUS, 8'h00);
      txc_pulse(2'(k));
      txc_pulse(2'(k));
      cyc(24);
      rdc("ct ready", OFF_INT_STATUS, 8'h08);
      i_duit_host_model.rd(OFF_STOP_READ, rw, rs);
    end
    // Timer on the crystal clock, 64 ticks a half period.
    wr(OFF_AUX_CONTROL, 8'h60);
    wr(OFF_PRELOAD_UPPER, 8'h00);
    wr(OFF_PRELOAD_LOWER, 8'h40);
    i_duit_host_model.rd(OFF_START_READ, rw, rs);
    cyc(140);
    rdc("status", OFF_INT_STATUS, 8'h08);
    rdc("count lo", OFF_COUNT_LOWER, 8'h00);
    i_duit_host_model.rd(OFF_STOP_READ, rw, rs);
    rdc("status", OFF_INT_STATUS, 8'h00);
    n = 0;
    last_ct = ct_output;
    for (k = 0; k < 80; k++)
    begin
      @(posedge clk);
      if (ct_output !== last_ct)
        n++;
      last_ct = ct_output;
    end
    chk("timer runs", 1, n > 0);
    @(posedge clk);
    rstn <= 1'b0;
    cyc(2);
    rstn <= 1'b1;
    cyc(2);
    rdc("status", OFF_INT_STATUS, 8'h00);
    chk("ct_output", 1, ct_output);
    report_and_stop;
  end
endmodule
`default_nettype wire
